/* File: common/rpsl_pkg.sv */
package rpsl_pkg;

   // loader sequence
   typedef enum logic [1:0] {
      RPSL_ST_IDLE  = 2'b00,
      RPSL_ST_CHECK = 2'b01,
      RPSL_ST_DONE  = 2'b10
   } rpsl_state_t;

   // request and start bits from the master
   typedef struct packed {
      logic pos_req;
      logic spd_req;
      logic fwd;
      logic rev;
   } rpsl_req_t;

   // latched positioning target
   typedef struct packed {
      logic [31:0] position;
      logic [15:0] table_no;
      logic [15:0] speed;
      logic [15:0] ramp_table;
   } rpsl_target_t;

endpackage

/* File: common/rpsl_regs.svh */
`ifndef RPSL_REGS_SVH
`define RPSL_REGS_SVH

// remote register word offsets, counted in 16-bit words
`define RPSL_OFS_RESPOND 3'h2
`define RPSL_OFS_WORD_LOW 3'h4
`define RPSL_OFS_WORD_HIGH 3'h5
`define RPSL_OFS_WORD_SPEED 3'h6
`define RPSL_WORD_COUNT 8

// positioning mode parameter encodings
`define RPSL_MODE_TABLE 2'h0
`define RPSL_MODE_POS_TABLE 2'h1
`define RPSL_MODE_POS_SPEED 2'h2

// respond code values
`define RPSL_RESP_NORMAL 16'h0000
`define RPSL_RESP_RANGE 16'h0003

// link stations that must be occupied
`define RPSL_STATIONS_NEEDED 3'h2

// table entry that supplies the ramps when speed comes from the registers
`define RPSL_ACCEL_TABLE 16'h0001

// lowest legal point table number
`define RPSL_TABLE_FIRST 16'h0001

`endif

/* File: src/rpsl_loader.sv */
`timescale 1ns/1ps
`include "rpsl_regs.svh"
// Notes on behaviour
// - loading works only when selected and two stations
// - initial mode takes a point table number only
// - mode one: position from words, speed from table
// - mode two: position and speed both from words
// - request latches table number on the same edge that completion rises
// - table number out of range gives error code
// - mode one latches position and table, both completions
// - mode one: any bad word reports range error
// - mode two: speed from word six, ramps table one
// - mode two latches position and speed, both completions
// - mode two: bad position or speed reports error
// - latched targets are volatile, cleared by reset
// - respond zero normal, three write range error
module rpsl_loader #(
   parameter logic [15:0] TABLE_LAST = 16'h00FF,
   parameter logic [31:0] POS_LIMIT = 32'h000F423F,
   parameter logic [15:0] SPEED_LIMIT = 16'h1770
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // link configuration
   input wire logic register_positioning_select_in,
   input wire logic [2:0] station_count_in,
   input wire logic [1:0] positioning_mode_parameter_in,
   // remote bits from the master
   input wire logic position_request_in,
   input wire logic speed_request_in,
   input wire logic forward_start_in,
   input wire logic reverse_start_in,
   // remote write words from the master
   input wire logic [`RPSL_WORD_COUNT-1:0][15:0] remote_words_in,
   // remote bits and words back to the master
   output logic position_complete_out,
   output logic speed_complete_out,
   output logic [15:0] response_result_code_out,
   // latched target and start towards motion control
   output logic [31:0] target_position_out,
   output logic [15:0] target_table_out,
   output logic [15:0] target_speed_out,
   output logic [15:0] ramp_table_out,
   output logic target_uses_position_out,
   output logic target_uses_speed_out,
   output logic forward_run_out,
   output logic reverse_run_out
);

   // synchronised remote bits
   rpsl_pkg::rpsl_req_t req_raw;
   rpsl_pkg::rpsl_req_t req_s;
   logic [3:0] req_sync;

   assign req_raw.pos_req = position_request_in;
   assign req_raw.spd_req = speed_request_in;
   assign req_raw.fwd = forward_start_in;
   assign req_raw.rev = reverse_start_in;

   rpsl_sync #(
      .WIDTH(4)
   ) u_req_sync (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .async_in(req_raw),
      .sync_out(req_sync)
   );

   assign req_s = req_sync;

   // words are sampled one stage; the master holds them stable before it
   // raises a request, so they have long settled when the request arrives
   logic [15:0] word_low_r;
   logic [15:0] word_high_r;
   logic [15:0] word_speed_r;
   logic [1:0] mode_cfg_r;
   logic select_r;
   logic [2:0] stations_r;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         word_low_r <= 16'h0000;
         word_high_r <= 16'h0000;
         word_speed_r <= 16'h0000;
         mode_cfg_r <= `RPSL_MODE_TABLE;
         select_r <= 1'b0;
         stations_r <= 3'h0;
      end else begin
         word_low_r <= remote_words_in[`RPSL_OFS_WORD_LOW];
         word_high_r <= remote_words_in[`RPSL_OFS_WORD_HIGH];
         word_speed_r <= remote_words_in[`RPSL_OFS_WORD_SPEED];
         mode_cfg_r <= positioning_mode_parameter_in;
         select_r <= register_positioning_select_in;
         stations_r <= station_count_in;
      end
   end

   // feature gate and mode decode
   logic enabled;
   logic mode_table;
   logic mode_pos_table;
   logic mode_pos_speed;
   logic mode_valid;
   logic both_needed;

   assign enabled = select_r && (stations_r == `RPSL_STATIONS_NEEDED);
   assign mode_table = (mode_cfg_r == `RPSL_MODE_TABLE);
   assign mode_pos_table = (mode_cfg_r == `RPSL_MODE_POS_TABLE);
   assign mode_pos_speed = (mode_cfg_r == `RPSL_MODE_POS_SPEED);
   assign mode_valid = mode_table || mode_pos_table || mode_pos_speed;
   assign both_needed = mode_pos_table || mode_pos_speed;

   // request recognised: table mode needs position request, others need both
   logic req_seen;
   logic req_held;

   assign req_seen = both_needed ? (req_s.pos_req && req_s.spd_req) : req_s.pos_req;
   assign req_held = both_needed ? (req_s.pos_req && req_s.spd_req) : req_s.pos_req;

   // range checks on the sampled words
   logic [31:0] pos_word;
   logic pos_neg;
   logic [31:0] pos_mag;
   logic pos_bad;
   logic table_low_bad;
   logic table_speed_bad;
   logic speed_bad;
   logic range_err;

   assign pos_word = {word_high_r, word_low_r};
   assign pos_neg = pos_word[31];
   assign pos_mag = pos_neg ? (32'h00000000 - pos_word) : pos_word;
   assign pos_bad = (pos_mag > POS_LIMIT);
   assign table_low_bad = (word_low_r < `RPSL_TABLE_FIRST) || (word_low_r > TABLE_LAST);
   assign table_speed_bad = (word_speed_r < `RPSL_TABLE_FIRST) || (word_speed_r > TABLE_LAST);
   assign speed_bad = (word_speed_r > SPEED_LIMIT);

   // error selection per mode
   always_comb begin
      case (mode_cfg_r)
         `RPSL_MODE_TABLE: range_err = table_low_bad;
         `RPSL_MODE_POS_TABLE: range_err = pos_bad || table_speed_bad;
         `RPSL_MODE_POS_SPEED: range_err = pos_bad || speed_bad;
         default: range_err = 1'b1;
      endcase
   end

   // loader sequence
   rpsl_pkg::rpsl_state_t state_r;
   rpsl_pkg::rpsl_state_t state_nxt;
   logic [1:0] mode_lat_r;
   logic mode_changed;

   assign mode_changed = (mode_lat_r != mode_cfg_r);

   // a dropped gate or a mode change abandons the handshake, so the master
   // never sees a completion that belongs to another mode
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         rpsl_pkg::RPSL_ST_IDLE: begin
            if (enabled && mode_valid && req_seen) begin
               state_nxt = rpsl_pkg::RPSL_ST_CHECK;
            end
         end
         rpsl_pkg::RPSL_ST_CHECK: begin
            state_nxt = rpsl_pkg::RPSL_ST_DONE;
         end
         rpsl_pkg::RPSL_ST_DONE: begin
            if (!enabled || mode_changed || !req_held) begin
               state_nxt = rpsl_pkg::RPSL_ST_IDLE;
            end
         end
         default: begin
            state_nxt = rpsl_pkg::RPSL_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_r <= rpsl_pkg::RPSL_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // latch stage: targets update only on a clean check
   rpsl_pkg::rpsl_target_t target_r;
   rpsl_pkg::rpsl_target_t target_nxt;
   logic uses_pos_r;
   logic uses_spd_r;
   logic [15:0] resp_r;
   logic checking;

   assign checking = (state_r == rpsl_pkg::RPSL_ST_CHECK);

   // what each mode stores
   always_comb begin
      target_nxt = target_r;
      case (mode_cfg_r)
         `RPSL_MODE_TABLE: begin
            target_nxt.table_no = word_low_r;
         end
         `RPSL_MODE_POS_TABLE: begin
            target_nxt.position = pos_word;
            target_nxt.table_no = word_speed_r;
         end
         `RPSL_MODE_POS_SPEED: begin
            target_nxt.position = pos_word;
            target_nxt.speed = word_speed_r;
            target_nxt.ramp_table = `RPSL_ACCEL_TABLE;
         end
         default: begin
            target_nxt = target_r;
         end
      endcase
   end

   // targets live in plain registers and come back cleared after reset
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         target_r <= '0;
         uses_pos_r <= 1'b0;
         uses_spd_r <= 1'b0;
         mode_lat_r <= `RPSL_MODE_TABLE;
         resp_r <= `RPSL_RESP_NORMAL;
      end else if (checking) begin
         mode_lat_r <= mode_cfg_r;
         resp_r <= range_err ? `RPSL_RESP_RANGE : `RPSL_RESP_NORMAL;
         if (!range_err) begin
            target_r <= target_nxt;
            uses_pos_r <= both_needed;
            uses_spd_r <= mode_pos_speed;
         end
      end
   end

   // completion bits follow the sequence; speed completion only in the
   // register modes, where the master waits for both
   logic pos_done_nxt;
   logic spd_done_nxt;
   logic pos_done_r;
   logic spd_done_r;

   assign pos_done_nxt = (state_nxt == rpsl_pkg::RPSL_ST_DONE);
   assign spd_done_nxt = pos_done_nxt && both_needed;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pos_done_r <= 1'b0;
         spd_done_r <= 1'b0;
      end else begin
         pos_done_r <= pos_done_nxt;
         spd_done_r <= spd_done_nxt;
      end
   end

   // start is passed on only once every needed completion is up; this
   // shields the motion side from a master that starts too early
   logic start_ok;
   logic fwd_run_r;
   logic rev_run_r;

   assign start_ok = pos_done_r && (spd_done_r || !both_needed) && (resp_r == `RPSL_RESP_NORMAL);

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fwd_run_r <= 1'b0;
         rev_run_r <= 1'b0;
      end else begin
         fwd_run_r <= start_ok && req_s.fwd && !req_s.rev;
         rev_run_r <= start_ok && req_s.rev && !req_s.fwd;
      end
   end

   // outputs, all from flip-flops
   assign position_complete_out = pos_done_r;
   assign speed_complete_out = spd_done_r;
   assign response_result_code_out = resp_r; // word at RPSL_OFS_RESPOND
   assign target_position_out = target_r.position;
   assign target_table_out = target_r.table_no;
   assign target_speed_out = target_r.speed;
   assign ramp_table_out = target_r.ramp_table;
   assign target_uses_position_out = uses_pos_r;
   assign target_uses_speed_out = uses_spd_r;
   assign forward_run_out = fwd_run_r;
   assign reverse_run_out = rev_run_r;

endmodule

/* File: src/rpsl_sync.sv */
`timescale 1ns/1ps
// three-stage synchroniser; a bit changes once stages two and three agree
module rpsl_sync #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // asynchronous levels in, filtered levels out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] stage2_r;
   logic [WIDTH-1:0] stage3_r;
   logic [WIDTH-1:0] out_r;
   logic [WIDTH-1:0] agree;
   logic [WIDTH-1:0] out_nxt;

   // meta_r feeds stage2_r only, never the agreement logic
   assign agree = ~(stage2_r ^ stage3_r);
   assign out_nxt = (agree & stage3_r) | (~agree & out_r);
   assign sync_out = out_r;

   // shift chain
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_r <= '0;
         stage2_r <= '0;
         stage3_r <= '0;
         out_r <= '0;
      end else begin
         meta_r <= async_in;
         stage2_r <= meta_r;
         stage3_r <= stage2_r;
         out_r <= out_nxt;
      end
   end

endmodule

/* File: test/remote_position_speed_loader_test.sv */
`timescale 1ns/1ps
`include "rpsl_regs.svh"
module remote_position_speed_loader_test;
   localparam logic [15:0] TL = 16'h00FF;
   localparam logic [31:0] PL = 32'h000F423F;
   localparam logic [15:0] SL = 16'h1770;
   localparam logic [31:0] PN = -PL;
   logic ref_clk_in;
   logic resetn_in;
   logic select;
   logic [2:0] stations;
   logic [1:0] mode;
   rpsl_pkg::rpsl_req_t req;
   logic [`RPSL_WORD_COUNT-1:0][15:0] words;
   logic pos_cpl, spd_cpl, uses_pos, uses_spd, fwd_run, rev_run;
   logic [15:0] resp, tbl, spd, ramp;
   logic [31:0] pos;
   logic ok;
   int errors, n_checks;
   rpsl_loader #(.TABLE_LAST(TL), .POS_LIMIT(PL), .SPEED_LIMIT(SL)) dut_u (.ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in), .register_positioning_select_in(select), .station_count_in(stations),
      .positioning_mode_parameter_in(mode), .position_request_in(req.pos_req), .speed_request_in(req.spd_req),
      .forward_start_in(req.fwd), .reverse_start_in(req.rev), .remote_words_in(words),
      .position_complete_out(pos_cpl), .speed_complete_out(spd_cpl), .response_result_code_out(resp),
      .target_position_out(pos), .target_table_out(tbl), .target_speed_out(spd), .ramp_table_out(ramp),
      .target_uses_position_out(uses_pos), .target_uses_speed_out(uses_spd), .forward_run_out(fwd_run),
      .reverse_run_out(rev_run));
   rpsl_master_model master_u (.ref_clk_in(ref_clk_in), .pos_cpl_in(pos_cpl), .spd_cpl_in(spd_cpl),
      .req_out(req), .words_out(words));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   // one load judged on respond code, completions and start gating
   task automatic run(input logic [15:0] w4, w5, w6, input logic rev, input logic [15:0] exp);
      master_u.load(w4, w5, w6, mode != `RPSL_MODE_TABLE, rev, 60, ok);
      // a missing completion is counted here; later waits stay bounded
      check(ok, 1'b1);
      @(negedge ref_clk_in);
      check(resp, exp);
      check(spd_cpl, mode != `RPSL_MODE_TABLE);
      cycles(10);
      check(rev ? rev_run : fwd_run, exp == `RPSL_RESP_NORMAL);
      check(rev ? fwd_run : rev_run, 1'b0);
      master_u.drop(60, ok);
      check(ok, 1'b1);
   endtask
   task automatic t_table();
      mode <= `RPSL_MODE_TABLE;
      cycles(4);
      run(16'h0005, 16'h0, 16'h0, 1'b0, `RPSL_RESP_NORMAL);
      check(tbl, 16'h0005);
      check(uses_pos, 1'b0);
      run(16'h0000, 16'h0, 16'h0, 1'b0, `RPSL_RESP_RANGE);
      run(TL + 16'h0001, 16'h0, 16'h0, 1'b1, `RPSL_RESP_RANGE);
      check(tbl, 16'h0005);
      $display("table mode test done");
   endtask
   task automatic t_pos_table();
      mode <= `RPSL_MODE_POS_TABLE;
      cycles(4);
      run(PL[15:0], PL[31:16], TL, 1'b0, `RPSL_RESP_NORMAL);
      check(pos, PL);
      check(tbl, TL);
      check(uses_pos, 1'b1);
      check(uses_spd, 1'b0);
      run(16'h4240, 16'h000F, 16'h0007, 1'b0, `RPSL_RESP_RANGE);
      run(16'h0010, 16'h0000, 16'h0000, 1'b0, `RPSL_RESP_RANGE);
      check(pos, PL);
      $display("position and table mode test done");
   endtask
   task automatic t_pos_speed();
      mode <= `RPSL_MODE_POS_SPEED;
      cycles(4);
      run(PN[15:0], PN[31:16], SL, 1'b1, `RPSL_RESP_NORMAL);
      check(pos, PN);
      check(spd, SL);
      check(ramp, `RPSL_ACCEL_TABLE);
      check(uses_spd, 1'b1);
      run(16'h0001, 16'h0000, SL + 16'h0001, 1'b0, `RPSL_RESP_RANGE);
      check(spd, SL);
      $display("position and speed mode test done");
   endtask
   // requests must be ignored when deselected or with one station
   task automatic t_off();
      mode <= `RPSL_MODE_TABLE;
      select <= 1'b0;
      cycles(10);
      master_u.load(16'h0003, 16'h0, 16'h0, 1'b0, 1'b0, 20, ok);
      check(ok, 1'b0);
      master_u.drop(20, ok);
      // let the dropped request clear the synchroniser before the gate opens
      cycles(8);
      select <= 1'b1;
      stations <= 3'h1;
      cycles(4);
      master_u.load(16'h0003, 16'h0, 16'h0, 1'b0, 1'b0, 20, ok);
      check(ok, 1'b0);
      master_u.drop(20, ok);
      cycles(8);
      // the unused mode code must not load anything
      mode <= 2'h3;
      stations <= `RPSL_STATIONS_NEEDED;
      cycles(4);
      master_u.load(16'h0003, 16'h0, 16'h0, 1'b0, 1'b0, 20, ok);
      check(ok, 1'b0);
      master_u.drop(20, ok);
      cycles(8);
      mode <= `RPSL_MODE_TABLE;
      cycles(4);
      $display("disabled test done");
   endtask
   // stored targets live only until the next reset
   task automatic t_reset();
      resetn_in <= 1'b0;
      cycles(2);
      check(pos, 32'h0);
      check(uses_pos, 1'b0);
      check(tbl, 16'h0000);
      check(resp, `RPSL_RESP_NORMAL);
      resetn_in <= 1'b1;
      cycles(2);
      check(pos_cpl, 1'b0);
      $display("reset test done");
   endtask
   initial begin
      ref_clk_in = 1'b0;
      forever #2 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      errors = 0;
      n_checks = 0;
      resetn_in = 1'b0;
      select = 1'b1;
      stations = `RPSL_STATIONS_NEEDED;
      mode = `RPSL_MODE_TABLE;
      cycles(2);
      resetn_in <= 1'b1;
      cycles(2);
      t_table();
      t_pos_table();
      t_pos_speed();
      t_off();
      t_reset();
      print_verdict();
   end
endmodule
bind rpsl_loader rpsl_loader_monitor mon_u (
   .ref_clk_in(ref_clk_in),
   .resetn_in(resetn_in),
   .register_positioning_select_in(register_positioning_select_in),
   .positioning_mode_parameter_in(positioning_mode_parameter_in),
   .position_request_in(position_request_in),
   .speed_request_in(speed_request_in),
   .position_complete_out(position_complete_out),
   .speed_complete_out(speed_complete_out),
   .response_result_code_out(response_result_code_out),
   .target_position_out(target_position_out),
   .ramp_table_out(ramp_table_out),
   .target_uses_speed_out(target_uses_speed_out),
   .forward_run_out(forward_run_out),
   .reverse_run_out(reverse_run_out)
);

/* File: test/rpsl_loader_monitor.sv */
`timescale 1ns/1ps
`include "rpsl_regs.svh"
// watches the loader handshake from its ports only
module rpsl_loader_monitor (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // master side
   input wire logic register_positioning_select_in,
   input wire logic [1:0] positioning_mode_parameter_in,
   input wire logic position_request_in,
   input wire logic speed_request_in,
   // device side
   input wire logic position_complete_out,
   input wire logic speed_complete_out,
   input wire logic [15:0] response_result_code_out,
   input wire logic [31:0] target_position_out,
   input wire logic [15:0] ramp_table_out,
   input wire logic target_uses_speed_out,
   input wire logic forward_run_out,
   input wire logic reverse_run_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   // eight cycles cover the one-flop select path with margin
   a_off_no_cpl: assert property ((!register_positioning_select_in) [*8] |-> !position_complete_out)
      else $error("completion while loading is deselected");
   a_resp_codes: assert property (response_result_code_out inside {`RPSL_RESP_NORMAL, `RPSL_RESP_RANGE})
      else $error("respond code outside normal and range error");
   a_cpl_cause: assert property ($rose(position_complete_out) |-> $past(position_request_in, 3))
      else $error("completion rose without a request");
   a_pos_drop: assert property ((!position_request_in) [*8] |-> !position_complete_out)
      else $error("position completion outlived its request");
   a_spd_drop: assert property ((!speed_request_in) [*8] |-> !speed_complete_out)
      else $error("speed completion outlived its request");
   a_mode0_spd: assert property ((positioning_mode_parameter_in == `RPSL_MODE_TABLE) [*8] |-> !speed_complete_out)
      else $error("speed completion in table mode");
   a_pair_cpl: assert property ($rose(position_complete_out)
      && positioning_mode_parameter_in != `RPSL_MODE_TABLE |-> speed_complete_out)
      else $error("completions not raised together");
   a_err_hold: assert property ($rose(position_complete_out)
      && response_result_code_out == `RPSL_RESP_RANGE |-> target_position_out == $past(target_position_out, 2))
      else $error("target changed on a range error");
   a_ramp_one: assert property ($rose(position_complete_out)
      && positioning_mode_parameter_in == `RPSL_MODE_POS_SPEED && response_result_code_out == `RPSL_RESP_NORMAL
      |-> ramp_table_out == `RPSL_ACCEL_TABLE && target_uses_speed_out)
      else $error("ramps not from table one");
   a_run_gate: assert property (forward_run_out || reverse_run_out |-> $past(position_complete_out))
      else $error("start passed without completion");
endmodule

/* File: test/rpsl_master_model.sv */
`timescale 1ns/1ps
`include "rpsl_regs.svh"
// master station: words first, then requests, start only after completion
module rpsl_master_model (
   // clock
   input wire logic ref_clk_in,
   // completions from the device
   input wire logic pos_cpl_in,
   input wire logic spd_cpl_in,
   // remote bits and words to the device
   output rpsl_pkg::rpsl_req_t req_out,
   output logic [`RPSL_WORD_COUNT-1:0][15:0] words_out
);
   // idle master holds everything low
   initial begin
      req_out = '0;
      words_out = '0;
   end
   // one load; ok stays low if completion never came within lim cycles
   task automatic load(input logic [15:0] w4, w5, w6, input logic both, rev, input int lim, output logic ok);
      int n;
      words_out[`RPSL_OFS_WORD_LOW] <= w4;
      words_out[`RPSL_OFS_WORD_HIGH] <= w5;
      words_out[`RPSL_OFS_WORD_SPEED] <= w6;
      @(posedge ref_clk_in);
      req_out.pos_req <= 1'b1;
      req_out.spd_req <= both;
      n = 0;
      ok = 1'b0;
      while (n < lim && !ok) begin
         @(posedge ref_clk_in);
         ok = pos_cpl_in && (spd_cpl_in || !both);
         n++;
      end
      // never start ahead of the completions
      if (ok) begin
         req_out.fwd <= !rev;
         req_out.rev <= rev;
      end
   endtask
   // release all bits and wait for the completions to fall
   task automatic drop(input int lim, output logic ok);
      int n;
      req_out <= '0;
      n = 0;
      ok = 1'b0;
      while (n < lim && !ok) begin
         @(posedge ref_clk_in);
         ok = !pos_cpl_in && !spd_cpl_in;
         n++;
      end
   endtask
endmodule
